// ===== logic/fdsr_regs.sv
// Floppy controller status registers A and B and drive output control register.
//
// Overview of operation
// - Basic mode: status A read floats bus.
// - Enhanced A bit0: head direction, resets zero.
// - Enhanced A: irq, drive2, step, track0 bits.
// - Enhanced A: head side, index, write protect.
// - Alternate A: inverted bits, DMA request.
// - Alternate A bit5: step latch, cleared.
// - Basic mode: status B read floats bus.
// - Enhanced B bits 6,7 read one.
// - Enhanced B bits 0,1: motor outputs.
// - Enhanced B bit2: live write gate.
// - Enhanced B bits 3,4: data toggles.
// - Enhanced B bit5 mirrors drive select.
// - Alternate B: drive selects active low.
// - Alternate B bit2: write gate latch.
// - Alternate B bits 3,4: data latches.
// - Output control: hard reset zero, writable.
// - Low bits decode one of four drives.
// - Bit2 zero holds soft reset.
// - Soft reset lasts at least 100ns.
// - Basic/alternate: bit3 gates DMA, irq pins.
// - Enhanced: DMA, irq pins always enabled.
// - Bits 4-7 drive motor outputs.

`timescale 1ns/100ps
`default_nettype none

module fdsr_regs (
	input  wire logic                      ref_clk,
	input  wire logic                      reset,
	// Host I/O pins.
	input  wire logic [fdsr_pkg::ADDR_W-1:0] hostAddr,
	input  wire logic                      hostRd_n,
	input  wire logic                      hostWr_n,
	input  wire logic [7:0]                hostDataIn,
	output logic      [7:0]                hostDataOut,
	output logic                           hostDataOe,
	// Configuration and controller-side signals.
	input  wire fdsr_pkg::fdsr_mode_type   compatMode,
	input  wire logic                      floppyIrqOut,
	input  wire logic                      dmaReqOut,
	input  wire logic                      stepOut,
	input  wire logic                      dirOut,
	input  wire logic                      headSideSelect,
	input  wire logic                      writeGate,
	input  wire logic                      writeData_n,
	input  wire logic                      inputRegRead,
	// Drive interface inputs.
	input  wire logic                      secondDrivePresent_n,
	input  wire logic                      trackZero_n,
	input  wire logic                      indexPulse_n,
	input  wire logic                      writeProtect_n,
	input  wire logic                      readData_n,
	// Drive and controller outputs.
	output logic      [3:0]                driveSelectLine,
	output logic      [3:0]                motorOn,
	output logic                           softReset_n,
	output logic                           dmaIrqPinEnable
);

	// ****************************************
	// Functions
	// ****************************************

	// Turns a binary drive number into a one-hot select.
	function automatic logic [3:0] driveDecode(input logic [1:0] num);
		logic [3:0] hot;
		hot = 4'h0;
		hot[num] = 1'b1;
		return hot;
	endfunction : driveDecode

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [fdsr_pkg::ADDR_W-1:0] addrMeta_reg;
	logic [fdsr_pkg::ADDR_W-1:0] addrSync_reg;
	logic [7:0]                  dataMeta_reg;
	logic [7:0]                  dataSync_reg;
	logic                        rdMeta_reg;
	logic                        rdSync_reg;
	logic                        wrMeta_reg;
	logic                        wrSync_reg;
	logic                        wrPrev_reg;
	logic [4:0]                  pinMeta_reg;
	logic [4:0]                  pinSync_reg;
	logic                        readDataPrev_reg;

	// Every host and drive pin passes two flip-flops before use.
	always_ff @(posedge ref_clk) begin
		addrMeta_reg <= hostAddr;
		addrSync_reg <= addrMeta_reg;
		dataMeta_reg <= hostDataIn;
		dataSync_reg <= dataMeta_reg;
		rdMeta_reg   <= ~hostRd_n;
		rdSync_reg   <= rdMeta_reg;
		wrMeta_reg   <= ~hostWr_n;
		wrSync_reg   <= wrMeta_reg;
		pinMeta_reg  <= {readData_n, secondDrivePresent_n, trackZero_n,
			indexPulse_n, writeProtect_n};
		pinSync_reg  <= pinMeta_reg;
	end

	// Named views of the synchronised drive pins.
	wire logic wpSync_n    = pinSync_reg[0];
	wire logic indexSync_n = pinSync_reg[1];
	wire logic trk0Sync_n  = pinSync_reg[2];
	wire logic drv2Sync_n  = pinSync_reg[3];
	wire logic rdataSync_n = pinSync_reg[4];

	// ****************************************
	// Address decode
	// ****************************************
	wire logic hitStatusA = (addrSync_reg == fdsr_pkg::ADDR_STATUS_A);
	wire logic hitStatusB = (addrSync_reg == fdsr_pkg::ADDR_STATUS_B);
	wire logic hitOutCtrl = (addrSync_reg == fdsr_pkg::ADDR_OUT_CTRL);
	wire logic writeStrobe = wrSync_reg & ~wrPrev_reg;
	wire logic isBasic = (compatMode == fdsr_pkg::MODE_BASIC);
	wire logic isEnh   = (compatMode == fdsr_pkg::MODE_ENH);

	// ****************************************
	// Drive output control register
	// ****************************************
	logic [7:0] driveOutputControl_reg;
	logic [7:0] driveOutputControl_next;

	// Writes are taken on the leading edge of the write strobe.
	assign driveOutputControl_next = (writeStrobe && hitOutCtrl) ?
		dataSync_reg : driveOutputControl_reg;

	// Only a hardware reset clears it; soft reset never touches it.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			driveOutputControl_reg <= fdsr_pkg::DOC_RESET_VAL;
			wrPrev_reg             <= 1'b0;
		end else begin
			driveOutputControl_reg <= driveOutputControl_next;
			wrPrev_reg             <= wrSync_reg;
		end
	end

	wire logic [1:0] driveNum =
		driveOutputControl_reg[fdsr_pkg::DOC_SEL_HI:fdsr_pkg::DOC_SEL_LO];
	wire logic [3:0] driveHot = driveDecode(driveNum);
	wire logic [3:0] motorBits =
		driveOutputControl_reg[fdsr_pkg::DOC_MOTOR_HI:fdsr_pkg::DOC_MOTOR_LO];
	wire logic resetBit = driveOutputControl_reg[fdsr_pkg::DOC_RESET_N];
	wire logic dmaGateBit = driveOutputControl_reg[fdsr_pkg::DOC_DMA_GATE];

	// ****************************************
	// Drive select and motor outputs
	// ****************************************
	logic [3:0] driveSelect_reg;
	logic [3:0] motorOn_reg;

	// One flip-flop per drive for each of its select and motor lines.
	for (genvar d = 0; d < 4; d++) begin : g_drive
		always_ff @(posedge ref_clk) begin
			if (reset) begin
				driveSelect_reg[d] <= 1'b0;
				motorOn_reg[d]     <= 1'b0;
			end else begin
				driveSelect_reg[d] <= driveHot[d];
				motorOn_reg[d]     <= motorBits[d];
			end
		end
	end

	// ****************************************
	// Software reset stretcher
	// ****************************************
	logic [fdsr_pkg::CNT_W-1:0] resetCnt_reg;
	logic [fdsr_pkg::CNT_W-1:0] resetCnt_next;
	logic                       softReset_n_reg;

	// While the bit is zero the counter reloads, so the reset output
	// stays low for the minimum width even after a quick rewrite.
	assign resetCnt_next = !resetBit ?
		fdsr_pkg::CNT_W'(fdsr_pkg::SOFT_RESET_CYC) :
		(resetCnt_reg != fdsr_pkg::CNT_ZERO) ?
		resetCnt_reg - 1'b1 : resetCnt_reg;

	// The controller stays in reset until the bit is one and the count ends.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			resetCnt_reg    <= fdsr_pkg::CNT_W'(fdsr_pkg::SOFT_RESET_CYC);
			softReset_n_reg <= 1'b0;
		end else begin
			resetCnt_reg    <= resetCnt_next;
			softReset_n_reg <= resetBit &
				(resetCnt_reg == fdsr_pkg::CNT_ZERO);
		end
	end

	// ****************************************
	// DMA and interrupt pin gating
	// ****************************************
	logic dmaIrqEnable_reg;

	// Enhanced mode keeps the pins enabled even through reset.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			dmaIrqEnable_reg <= isEnh;
		end else begin
			dmaIrqEnable_reg <= isEnh | dmaGateBit;
		end
	end

	// ****************************************
	// Edge detectors
	// ****************************************
	logic stepPrev_reg;
	logic wgatePrev_reg;
	logic wdataPrev_reg;

	// Previous values for edge detection; all on the block clock.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			stepPrev_reg     <= 1'b0;
			wgatePrev_reg    <= 1'b0;
			wdataPrev_reg    <= 1'b1;
			readDataPrev_reg <= 1'b1;
		end else begin
			stepPrev_reg     <= stepOut;
			wgatePrev_reg    <= writeGate;
			wdataPrev_reg    <= writeData_n;
			readDataPrev_reg <= rdataSync_n;
		end
	end

	// Data inputs are active low, so the inactive edge is rising.
	wire logic stepRise  = stepOut & ~stepPrev_reg;
	wire logic wgateRise = writeGate & ~wgatePrev_reg;
	wire logic wdataIdle = writeData_n & ~wdataPrev_reg;
	wire logic rdataIdle = rdataSync_n & ~readDataPrev_reg;

	// ****************************************
	// Toggles and latches
	// ****************************************
	logic rdToggle_reg;
	logic wdToggle_reg;
	logic stepLatch_reg;
	logic wgLatch_reg;
	logic rdLatch_reg;
	logic wdLatch_reg;

	// Toggles flip on each inactive data edge.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rdToggle_reg <= 1'b0;
			wdToggle_reg <= 1'b0;
		end else begin
			rdToggle_reg <= rdToggle_reg ^ rdataIdle;
			wdToggle_reg <= wdToggle_reg ^ wdataIdle;
		end
	end

	// Latches set on their edge; a set in the clearing cycle wins.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			stepLatch_reg <= 1'b0;
			wgLatch_reg   <= 1'b0;
			rdLatch_reg   <= 1'b0;
			wdLatch_reg   <= 1'b0;
		end else begin
			stepLatch_reg <= stepRise |
				(stepLatch_reg & ~inputRegRead & softReset_n_reg);
			wgLatch_reg   <= wgateRise | (wgLatch_reg & ~inputRegRead);
			rdLatch_reg   <= rdataIdle | (rdLatch_reg & ~inputRegRead);
			wdLatch_reg   <= wdataIdle | (wdLatch_reg & ~inputRegRead);
		end
	end

	// ****************************************
	// Status register layouts
	// ****************************************
	wire logic [7:0] statusAEnh = {floppyIrqOut, drv2Sync_n, stepOut,
		trk0Sync_n, headSideSelect, indexSync_n, wpSync_n,
		dirOut};

	wire logic [7:0] statusAAlt = {floppyIrqOut, dmaReqOut,
		stepLatch_reg, ~trk0Sync_n, ~headSideSelect, ~indexSync_n,
		~wpSync_n, ~dirOut};

	wire logic [7:0] statusBEnh = {fdsr_pkg::SRB_RSVD_ONES,
		driveOutputControl_reg[fdsr_pkg::DOC_SEL_LO],
		wdToggle_reg, rdToggle_reg,
		writeGate,
		motorOn_reg[1], motorOn_reg[0]};

	wire logic [7:0] statusBAlt = {drv2Sync_n, ~driveSelect_reg[1],
		~driveSelect_reg[0], wdLatch_reg, rdLatch_reg, wgLatch_reg,
		~driveSelect_reg[3], ~driveSelect_reg[2]};

	// ****************************************
	// Read path
	// ****************************************
	wire logic hitStatus = hitStatusA | hitStatusB;

	// Basic mode leaves the status addresses to float.
	wire logic readDrive = rdSync_reg &
		((hitStatus & ~isBasic) | hitOutCtrl);

	wire logic [7:0] statusA = isEnh ? statusAEnh : statusAAlt;
	wire logic [7:0] statusB = isEnh ? statusBEnh : statusBAlt;
	wire logic [7:0] readMux = hitStatusA ? statusA :
		hitStatusB ? statusB : driveOutputControl_reg;

	logic [7:0] dataOut_reg;
	logic       dataOe_reg;

	// Read data and its enable are registered for the pins.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			dataOut_reg <= fdsr_pkg::BYTE_ZERO;
			dataOe_reg  <= 1'b0;
		end else begin
			dataOut_reg <= readDrive ? readMux : fdsr_pkg::BYTE_ZERO;
			dataOe_reg  <= readDrive;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign hostDataOut     = dataOut_reg;
	assign hostDataOe      = dataOe_reg;
	assign driveSelectLine = driveSelect_reg;
	assign motorOn         = motorOn_reg;
	assign softReset_n     = softReset_n_reg;
	assign dmaIrqPinEnable = dmaIrqEnable_reg;

endmodule : fdsr_regs

`default_nettype wire

// ===== logic/fdsr_pkg.sv
// Constants shared by the floppy status and drive output register bank.
package fdsr_pkg;

	// ****************************************
	// Host I/O addresses
	// ****************************************
	localparam int               ADDR_W          = 10;
	localparam logic [ADDR_W-1:0] ADDR_STATUS_A   = 10'h3f0;
	localparam logic [ADDR_W-1:0] ADDR_STATUS_B   = 10'h3f1;
	localparam logic [ADDR_W-1:0] ADDR_OUT_CTRL   = 10'h3f2;

	// ****************************************
	// Output control field positions
	// ****************************************
	localparam int DOC_SEL_LO   = 0;
	localparam int DOC_SEL_HI   = 1;
	localparam int DOC_RESET_N  = 2;
	localparam int DOC_DMA_GATE = 3;
	localparam int DOC_MOTOR_LO = 4;
	localparam int DOC_MOTOR_HI = 7;

	// Reset values and fixed status B bits.
	localparam logic [7:0] DOC_RESET_VAL = 8'h00;
	localparam logic [1:0] SRB_RSVD_ONES = 2'h3;
	localparam logic [7:0] BYTE_ZERO     = 8'h00;

	// ****************************************
	// Compatibility modes
	// ****************************************
	typedef enum logic [1:0] {
		MODE_BASIC = 2'b00,
		MODE_ENH   = 2'b01,
		MODE_ALT   = 2'b10
	} fdsr_mode_type;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS     = 25;
	localparam int SOFT_RESET_MIN_NS = 100;
	localparam int SOFT_RESET_CYC    =
		(SOFT_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W             = 3;
	localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;

endpackage : fdsr_pkg

// ===== sim/fdsr_regs_asserts.sv
// Port assertions for the floppy status and drive output register bank.
`timescale 1ns/100ps
`default_nettype none
module fdsr_regs_asserts (
	input wire logic                        ref_clk,
	input wire logic                        reset,
	input wire logic [fdsr_pkg::ADDR_W-1:0] hostAddr,
	input wire logic                        hostWr_n,
	input wire logic [7:0]                  hostDataOut,
	input wire logic                        hostDataOe,
	input wire fdsr_pkg::fdsr_mode_type     compatMode,
	input wire logic [3:0]                  driveSelectLine,
	input wire logic [3:0]                  motorOn,
	input wire logic                        softReset_n,
	input wire logic                        dmaIrqPinEnable
);
	// ****************************************
	// Checks
	// ****************************************
	// Mode and address decodes shared by the checks.
	wire logic isBasic = compatMode == fdsr_pkg::MODE_BASIC;
	wire logic isEnh   = compatMode == fdsr_pkg::MODE_ENH;
	wire logic isAlt   = compatMode == fdsr_pkg::MODE_ALT;
	wire logic atA     = hostAddr == fdsr_pkg::ADDR_STATUS_A;
	wire logic atB     = hostAddr == fdsr_pkg::ADDR_STATUS_B;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	a_reset_clears: assert property (disable iff (1'h0) reset |=> motorOn == 4'h0 && !softReset_n)
		else $error("reset left motors or soft reset set");
	a_enh_reset_pins: assert property (disable iff (1'h0) reset && isEnh |=> dmaIrqPinEnable)
		else $error("pin gate dropped by reset in enhanced mode");
	a_one_select: assert property (!$past(reset) && !$past(reset, 2) |-> $onehot(driveSelectLine))
		else $error("drive selects not one-hot");
	a_basic_a_float: assert property ((isBasic && atA) [*5] |-> !hostDataOe)
		else $error("status A driven in basic mode");
	a_basic_b_float: assert property ((isBasic && atB) [*5] |-> !hostDataOe)
		else $error("status B driven in basic mode");
	a_enh_pins_on: assert property (isEnh |=> dmaIrqPinEnable)
		else $error("pin gate off in enhanced mode");
	a_soft_reset_min: assert property ($fell(softReset_n) |=> !softReset_n [*3])
		else $error("soft reset shorter than minimum");
	a_b_reserved_ones: assert property ((isEnh && atB) [*5] ##0 hostDataOe |-> hostDataOut[7:6] == 2'h3)
		else $error("reserved status B bits not one");
	a_b_motor_sel: assert property ((isEnh && atB && $stable(motorOn) && $stable(driveSelectLine))
		[*5] ##0 hostDataOe |-> hostDataOut[1:0] == motorOn[1:0]
		&& hostDataOut[5] == (driveSelectLine[1] | driveSelectLine[3]))
		else $error("status B motor or select bits wrong");
	a_alt_b_sel: assert property ((isAlt && atB && $stable(driveSelectLine)) [*5] ##0 hostDataOe
		|-> {hostDataOut[6:5], hostDataOut[1:0]} == ~{driveSelectLine[1:0], driveSelectLine[3:2]})
		else $error("alternate status B selects wrong");
	a_motor_by_write: assert property ($changed(motorOn) |-> !$past(hostWr_n, 3))
		else $error("motor lines changed without a write");
endmodule : fdsr_regs_asserts

bind fdsr_regs fdsr_regs_asserts i_fdsr_regs_asserts (
	.ref_clk(ref_clk), .reset(reset), .hostAddr(hostAddr), .hostWr_n(hostWr_n),
	.hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .compatMode(compatMode),
	.driveSelectLine(driveSelectLine), .motorOn(motorOn), .softReset_n(softReset_n),
	.dmaIrqPinEnable(dmaIrqPinEnable)
);
`default_nettype wire

// ===== sim/fdsr_drive_model.sv
// Behavioural floppy drive 0 on the drive interface.
`timescale 1ns/100ps
`default_nettype none
module fdsr_drive_model (
	input  wire logic [3:0] driveSelectLine,
	input  wire logic       wpOn,
	input  wire logic       trackZeroOn,
	input  wire logic       readLow,
	input  wire logic       indexOn,
	input  wire logic       drv2On,
	output logic            secondDrivePresent_n,
	output logic            trackZero_n,
	output logic            indexPulse_n,
	output logic            writeProtect_n,
	output logic            readData_n
);
	// Drive 0 answers when selected; otherwise its open-collector lines float to the pull-up level.
	// The second-drive presence pin is strapped by the bench.
	wire logic sel = driveSelectLine[0];
	assign secondDrivePresent_n = ~drv2On;
	assign trackZero_n          = ~(sel & trackZeroOn);
	assign indexPulse_n         = ~(sel & indexOn);
	assign writeProtect_n       = ~(sel & wpOn);
	assign readData_n           = ~(sel & readLow);
endmodule : fdsr_drive_model
`default_nettype wire

// ===== sim/tb.sv
// Self-checking testbench for the floppy register bank.
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic [9:0] hostAddr;
	logic [7:0] hostDataIn, hostDataOut, rdVal;
	logic       ref_clk, reset, hostRd_n, hostWr_n, hostDataOe, rdOe, wpOn, trackZeroOn, readLow;
	logic       floppyIrqOut, dmaReqOut, stepOut, dirOut, headSideSelect, writeGate, writeData_n, inputRegRead;
	logic       secondDrivePresent_n, trackZero_n, indexPulse_n, writeProtect_n, readData_n;
	logic       softReset_n, dmaIrqPinEnable;
	logic       indexOn, drv2On;
	logic [3:0] driveSelectLine, motorOn;
	fdsr_pkg::fdsr_mode_type compatMode;
	int         fail_count, n_tests;

	fdsr_regs i_fdsr_regs (.ref_clk, .reset, .hostAddr, .hostRd_n, .hostWr_n, .hostDataIn, .hostDataOut,
		.hostDataOe, .compatMode, .floppyIrqOut, .dmaReqOut, .stepOut, .dirOut, .headSideSelect, .writeGate,
		.writeData_n, .inputRegRead, .secondDrivePresent_n, .trackZero_n, .indexPulse_n, .writeProtect_n,
		.readData_n, .driveSelectLine, .motorOn, .softReset_n, .dmaIrqPinEnable);
	fdsr_drive_model i_fdsr_drive_model (.driveSelectLine, .wpOn, .trackZeroOn, .readLow, .indexOn, .drv2On,
		.secondDrivePresent_n, .trackZero_n, .indexPulse_n, .writeProtect_n, .readData_n);

	// ****************************************
	// Helpers
	// ****************************************
	// Clock of 25 ns period.
	initial begin
		ref_clk = 1'h0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// Waits edges, then steps just past the last one.
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Strobes are held well past the three-edge synchroniser latency.
	task automatic wr(input logic [7:0] d);
		hostAddr = fdsr_pkg::ADDR_OUT_CTRL;
		hostDataIn = d;
		hostWr_n = 1'h0;
		cyc(5);
		hostWr_n = 1'h1;
		cyc(6);
	endtask : wr
	// Reads one address and compares enable and data together.
	task automatic rdchk(input string what, input logic [9:0] a, input logic [8:0] exp);
		hostAddr = a;
		hostRd_n = 1'h0;
		cyc(5);
		rdVal = hostDataOut;
		rdOe = hostDataOe;
		hostRd_n = 1'h1;
		cyc(5);
		chk(what, exp, {rdOe, rdVal});
	endtask : rdchk
	task automatic pulse(ref logic s);
		s = 1'h1;
		cyc(1);
		s = 1'h0;
		cyc(4);
	endtask : pulse
	task automatic wd_pulse();
		writeData_n = 1'h0;
		cyc(1);
		writeData_n = 1'h1;
		cyc(4);
	endtask : wd_pulse

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_drives();
		logic [7:0] act [4] = '{8'h1c, 8'h2d, 8'h4e, 8'h8f};
		chk("reset motors", 9'h000, {5'h00, motorOn});
		chk("reset soft", 9'h000, {8'h00, softReset_n});
		rdchk("reset control", fdsr_pkg::ADDR_OUT_CTRL, 9'h100);
		for (int i = 0; i < 4; i++) begin
			wr(act[i]);
			chk("selects", 9'h001 << i, {5'h00, driveSelectLine});
			chk("motors", 9'h001 << i, {5'h00, motorOn});
			chk("pin gate", 9'h001, {8'h00, dmaIrqPinEnable});
			rdchk("control", fdsr_pkg::ADDR_OUT_CTRL, {1'h1, act[i]});
		end
		rdchk("basic A", fdsr_pkg::ADDR_STATUS_A, 9'h000);
		rdchk("basic B", fdsr_pkg::ADDR_STATUS_B, 9'h000);
		$display("test drives done");
	endtask : t_drives
	task automatic t_sreset();
		wr(8'h1c);
		wr(8'h18);
		chk("soft low", 9'h000, {8'h00, softReset_n});
		chk("motor kept", 9'h001, {5'h00, motorOn});
		wr(8'h1c);
		chk("soft high", 9'h001, {8'h00, softReset_n});
		wr(8'h14);
		chk("gate off", 9'h000, {8'h00, dmaIrqPinEnable});
		compatMode = fdsr_pkg::MODE_ENH;
		cyc(2);
		chk("gate enh", 9'h001, {8'h00, dmaIrqPinEnable});
		wr(8'h1c);
		$display("test soft reset done");
	endtask : t_sreset
	task automatic t_status_a();
		{floppyIrqOut, dirOut, headSideSelect, wpOn, trackZeroOn, dmaReqOut} = 6'h3f;
		rdchk("enh A", fdsr_pkg::ADDR_STATUS_A, 9'h1cd);
		{stepOut, indexOn, drv2On} = 3'h7;
		rdchk("enh A step", fdsr_pkg::ADDR_STATUS_A, 9'h1a9);
		stepOut = 1'h0;
		compatMode = fdsr_pkg::MODE_ALT;
		pulse(inputRegRead);
		rdchk("alt A", fdsr_pkg::ADDR_STATUS_A, 9'h1d6);
		pulse(stepOut);
		rdchk("alt A step", fdsr_pkg::ADDR_STATUS_A, 9'h1f6);
		pulse(inputRegRead);
		rdchk("alt A clear", fdsr_pkg::ADDR_STATUS_A, 9'h1d6);
		$display("test status A done");
	endtask : t_status_a
	task automatic t_status_b();
		compatMode = fdsr_pkg::MODE_ENH;
		writeGate = 1'h1;
		rdchk("enh B", fdsr_pkg::ADDR_STATUS_B, 9'h1c5);
		wd_pulse();
		rdchk("enh B wd", fdsr_pkg::ADDR_STATUS_B, 9'h1d5);
		pulse(readLow);
		rdchk("enh B rd", fdsr_pkg::ADDR_STATUS_B, 9'h1dd);
		wr(8'h2d);
		rdchk("enh B sel", fdsr_pkg::ADDR_STATUS_B, 9'h1fe);
		wr(8'h1c);
		compatMode = fdsr_pkg::MODE_ALT;
		writeGate = 1'h0;
		pulse(inputRegRead);
		rdchk("alt B", fdsr_pkg::ADDR_STATUS_B, 9'h143);
		wd_pulse();
		rdchk("alt B wd", fdsr_pkg::ADDR_STATUS_B, 9'h153);
		writeGate = 1'h1;
		pulse(readLow);
		rdchk("alt B set", fdsr_pkg::ADDR_STATUS_B, 9'h15f);
		pulse(inputRegRead);
		rdchk("alt B clear", fdsr_pkg::ADDR_STATUS_B, 9'h143);
		drv2On = 1'h0;
		wr(8'h8f);
		rdchk("alt B drive 3", fdsr_pkg::ADDR_STATUS_B, 9'h1e1);
		$display("test status B done");
	endtask : t_status_b
	// Hardware reset in mid-run, in enhanced mode with drive 1 running.
	task automatic t_hreset();
		compatMode = fdsr_pkg::MODE_ENH;
		writeGate = 1'h0;
		wr(8'h2d);
		reset = 1'h1;
		cyc(1);
		chk("reset pins enh", 9'h001, {8'h00, dmaIrqPinEnable});
		chk("reset motors mid", 9'h000, {5'h00, motorOn});
		cyc(1);
		reset = 1'h0;
		cyc(1);
		rdchk("reset B", fdsr_pkg::ADDR_STATUS_B, 9'h1c0);
		rdchk("reset control mid", fdsr_pkg::ADDR_OUT_CTRL, 9'h100);
		chk("reset soft mid", 9'h000, {8'h00, softReset_n});
		$display("test hardware reset done");
	endtask : t_hreset
	task automatic give_verdict();
		$display("%0d comparisons, %0d mismatches", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict

	// Main sequence with a six-cycle hardware reset.
	initial begin
		fail_count = 0;
		n_tests = 0;
		{hostAddr, hostDataIn, hostRd_n, hostWr_n, writeData_n} = 21'h0_0007;
		{floppyIrqOut, dmaReqOut, stepOut, dirOut, headSideSelect, writeGate, inputRegRead} = 7'h00;
		{wpOn, trackZeroOn, readLow, indexOn, drv2On} = 5'h00;
		compatMode = fdsr_pkg::MODE_BASIC;
		reset = 1'h1;
		cyc(6);
		reset = 1'h0;
		cyc(2);
		t_drives();
		t_sreset();
		t_status_a();
		t_status_b();
		t_hreset();
		give_verdict();
	end
endmodule : tb
`default_nettype wire
